/* core/mlc_pkg.sv */
// Package: constants, layouts and types for the monitor limit compare block
package mlc_pkg;

    localparam int          NUM_LIM       = 10;
    localparam int          NUM_CHAN      = 3;
    localparam int          LIM_W         = 16;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 12;
    localparam int          IDX_W         = 8;

    // Register indices as printed; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LIM [NUM_LIM] = '{
        8'h12, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20, 8'h22, 8'h24};
    localparam logic [IDX_W-1:0] IDX_ALARM_A   = 8'h70;
    localparam logic [IDX_W-1:0] IDX_ALARM_B   = 8'h71;
    localparam logic [IDX_W-1:0] IDX_WARN_A    = 8'h74;
    localparam logic [IDX_W-1:0] IDX_WARN_B    = 8'h75;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 8'h78;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLR   = 8'h79;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN    = 8'h7A;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 8'h7B;
    localparam logic [IDX_W-1:0] IDX_CTRL      = 8'h7C;

    // Channel and direction of each limit
    localparam logic [1:0] LIM_CHAN [NUM_LIM] = '{
        2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    localparam logic       LIM_HIGH [NUM_LIM] = '{
        1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    // Flag positions inside the flag bytes
    localparam int BIT_FIRST_MONITOR_INPUT_LO_ALM = 2;
    localparam int BIT_FIRST_MONITOR_INPUT_HI_WRN = 3;
    localparam int BIT_FIRST_MONITOR_INPUT_LO_WRN = 2;
    localparam int BIT_SECOND_MONITOR_INPUT_HI_ALM = 1;
    localparam int BIT_SECOND_MONITOR_INPUT_LO_ALM = 0;
    localparam int BIT_SECOND_MONITOR_INPUT_HI_WRN = 1;
    localparam int BIT_SECOND_MONITOR_INPUT_LO_WRN = 0;
    localparam int BIT_THIRD_MONITOR_INPUT_HI_ALM = 7;
    localparam int BIT_THIRD_MONITOR_INPUT_LO_ALM = 6;
    localparam int BIT_THIRD_MONITOR_INPUT_HI_WRN = 7;

    // Control and status fields
    localparam int BIT_CTRL_RELOAD = 0;
    localparam int BIT_STAT_BUSY   = 3;

    localparam logic [LIM_W-1:0]  LIM_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

    // Nonvolatile programming time per limit
    localparam int CLK_PERIOD_NS    = 40;
    localparam int NV_PROG_TIME_NS  = 200;
    localparam int NV_PROG_CYCLES   = (NV_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CNT_W       = 8;

    typedef struct packed {
        logic             valid;
        logic [1:0]       chan;
        logic [LIM_W-1:0] data;
    } mlc_meas_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_PROG = 1'b1
    } mlc_nv_state_t;

endpackage

/* core/mlc_monitor_limit_compare.sv */
// Limit bank and threshold compare for three monitor inputs, APB slave
`timescale 1ns/1ps

// Function
// - First input below low alarm limit sets alarm byte 70h bit 2; above clears.
// - First input above high warning limit sets warning byte 74h bit 3; below clears.
// - First input below low warning limit sets warning byte 74h bit 2; above clears.
// - Second input above high alarm limit sets alarm byte 70h bit 1; below clears.
// - Second input below low alarm limit sets alarm byte 70h bit 0; above clears.
// - Second input above high warning limit sets warning byte 74h bit 1; below clears.
// - Second input below low warning limit sets warning byte 74h bit 0; above clears.
// - Third input above high alarm limit sets alarm byte 71h bit 7; below clears.
// - Third input below low alarm limit sets alarm byte 71h bit 6; above clears.
// - Third input above high warning limit sets warning byte 75h bit 7; below clears.
// - Limits live in a working copy backed by nonvolatile store, default zero.
// - Flags read zero until their channel's first conversion, then follow compares.
module mlc_monitor_limit_compare
    import mlc_pkg::*;
(
    input  wire logic              CORE_CLK_IN,
    input  wire logic              RST_N_IN,
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic [ADDR_W-1:0] PADDR_IN,
    input  wire logic [DATA_W-1:0] PWDATA_IN,
    output logic      [DATA_W-1:0] PRDATA_OUT,
    output logic                   PREADY_OUT,
    output logic                   PSLVERR_OUT,
    input  wire mlc_meas_t         MEAS_IN,
    output logic [NUM_CHAN-1:0]    CONV_SEEN_OUT,
    output logic                   IRQ_OUT
);

    logic                  rst_meta_reg;
    logic                  rst_n;
    logic [LIM_W-1:0]      lim_reg [NUM_LIM];
    logic [LIM_W-1:0]      nv_reg  [NUM_LIM];
    logic [NUM_LIM-1:0]    flag_reg;
    logic [NUM_LIM-1:0]    flag_next;
    logic [NUM_CHAN-1:0]   seen_reg;
    logic [NUM_LIM-1:0]    irq_stat_reg;
    logic [NUM_LIM-1:0]    irq_en_reg;
    logic [NUM_LIM-1:0]    irq_clr;
    logic [DATA_W-1:0]     prdata_reg;
    mlc_nv_state_t         nv_state_reg;
    logic [PROG_CNT_W-1:0] prog_cnt_reg;
    logic [3:0]            prog_idx_reg;
    logic [7:0]            alarm_a;
    logic [7:0]            alarm_b;
    logic [7:0]            warn_a;
    logic [7:0]            warn_b;
    logic [IDX_W-1:0]      idx;
    logic                  addr_ok;
    logic                  lim_hit;
    logic [3:0]            lim_sel;
    logic                  mapped;
    logic                  access;
    logic                  wr_stall;
    logic                  wr_fire;
    logic                  reload;

    // {above, below}: unsigned compare of a measurement against a limit
    function automatic logic [1:0] cmp_lim(input logic [LIM_W-1:0] meas,
                                           input logic [LIM_W-1:0] lim);
        cmp_lim = {meas > lim, meas < lim};
    endfunction

    // Reset release through two flops
    always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // Address decode
    always_comb begin
        idx     = PADDR_IN[IDX_W+1:2];
        addr_ok = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN[ADDR_W-1:IDX_W+2] == '0);
        lim_hit = 1'b0;
        lim_sel = 4'h0;
        for (int i = 0; i < NUM_LIM; i++) begin
            if (idx == IDX_LIM[i]) begin
                lim_hit = addr_ok;
                lim_sel = 4'(i);
            end
        end
        mapped = lim_hit || (addr_ok && (idx == IDX_ALARM_A || idx == IDX_ALARM_B
                 || idx == IDX_WARN_A || idx == IDX_WARN_B || idx == IDX_IRQ_STAT
                 || idx == IDX_IRQ_CLR || idx == IDX_IRQ_EN || idx == IDX_STATUS
                 || idx == IDX_CTRL));
    end

    // A limit write or a reload waits while the store is still programming;
    // a reload taken mid-programming would restore a stale limit
    assign access      = PSEL_IN && PENABLE_IN;
    assign wr_stall    = PWRITE_IN && (lim_hit || (addr_ok && idx == IDX_CTRL))
                         && (nv_state_reg == ST_PROG);
    assign PREADY_OUT  = !(access && wr_stall);
    assign PSLVERR_OUT = access && PREADY_OUT && !mapped;
    assign wr_fire     = access && PREADY_OUT && PWRITE_IN && mapped;
    assign reload      = wr_fire && addr_ok && (idx == IDX_CTRL)
                         && PWDATA_IN[BIT_CTRL_RELOAD];

    // Working copy of the limits
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_LIM; i++) begin
                lim_reg[i] <= LIM_RESET;
            end
        end else if (reload) begin
            for (int i = 0; i < NUM_LIM; i++) begin
                lim_reg[i] <= nv_reg[i];
            end
        end else if (wr_fire && lim_hit) begin
            lim_reg[lim_sel] <= PWDATA_IN[LIM_W-1:0];
        end
    end

    // Write-through into the nonvolatile store, one limit at a time
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            nv_state_reg <= ST_IDLE;
            prog_cnt_reg <= '0;
            prog_idx_reg <= 4'h0;
        end else begin
            unique case (nv_state_reg)
                ST_IDLE: begin
                    if (wr_fire && lim_hit) begin
                        nv_state_reg <= ST_PROG;
                        prog_cnt_reg <= PROG_CNT_W'(NV_PROG_CYCLES - 1);
                        prog_idx_reg <= lim_sel;
                    end
                end
                ST_PROG: begin
                    if (prog_cnt_reg == '0) begin
                        nv_state_reg <= ST_IDLE;
                    end else begin
                        prog_cnt_reg <= prog_cnt_reg - 1'b1;
                    end
                end
            endcase
        end
    end

    // Store cells committed at the end of programming; factory content is zero
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_LIM; i++) begin
                nv_reg[i] <= LIM_RESET;
            end
        end else if (nv_state_reg == ST_PROG && prog_cnt_reg == '0) begin
            nv_reg[prog_idx_reg] <= lim_reg[prog_idx_reg];
        end
    end

    // Compare each new measurement against every limit of its channel
    always_comb begin
        logic [1:0] res;
        logic       set;
        logic       clr;
        res       = 2'b00;
        set       = 1'b0;
        clr       = 1'b0;
        flag_next = flag_reg;
        for (int i = 0; i < NUM_LIM; i++) begin
            if (MEAS_IN.valid && MEAS_IN.chan == LIM_CHAN[i]) begin
                res = cmp_lim(MEAS_IN.data, lim_reg[i]);
                set = LIM_HIGH[i] ? res[1] : res[0];
                clr = LIM_HIGH[i] ? res[0] : res[1];
                if (set) begin
                    flag_next[i] = 1'b1;
                end else if (clr) begin
                    flag_next[i] = 1'b0;
                end else if (!seen_reg[LIM_CHAN[i]]) begin
                    // Equal on the first conversion: start from clear
                    flag_next[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Channels that have completed a conversion since reset
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            seen_reg <= '0;
        end else if (MEAS_IN.valid && MEAS_IN.chan < 2'(NUM_CHAN)) begin
            seen_reg[MEAS_IN.chan] <= 1'b1;
        end
    end

    assign CONV_SEEN_OUT = seen_reg;

    // Flag bytes; a channel not yet converted reads zero
    always_comb begin
        logic [NUM_LIM-1:0] f;
        f = '0;
        for (int i = 0; i < NUM_LIM; i++) begin
            f[i] = flag_reg[i] && seen_reg[LIM_CHAN[i]];
        end
        alarm_a = 8'h00;
        alarm_b = 8'h00;
        warn_a  = 8'h00;
        warn_b  = 8'h00;
        alarm_a[BIT_FIRST_MONITOR_INPUT_LO_ALM] = f[0];
        warn_a[BIT_FIRST_MONITOR_INPUT_HI_WRN]  = f[1];
        warn_a[BIT_FIRST_MONITOR_INPUT_LO_WRN]  = f[2];
        alarm_a[BIT_SECOND_MONITOR_INPUT_HI_ALM] = f[3];
        alarm_a[BIT_SECOND_MONITOR_INPUT_LO_ALM] = f[4];
        warn_a[BIT_SECOND_MONITOR_INPUT_HI_WRN]  = f[5];
        warn_a[BIT_SECOND_MONITOR_INPUT_LO_WRN]  = f[6];
        alarm_b[BIT_THIRD_MONITOR_INPUT_HI_ALM] = f[7];
        alarm_b[BIT_THIRD_MONITOR_INPUT_LO_ALM] = f[8];
        warn_b[BIT_THIRD_MONITOR_INPUT_HI_WRN]  = f[9];
    end

    // Sticky event bits: a flag going high; a new event beats a clear
    assign irq_clr = (wr_fire && idx == IDX_IRQ_CLR) ? PWDATA_IN[NUM_LIM-1:0] : '0;

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | (flag_next & ~flag_reg);
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg <= '0;
        end else if (wr_fire && idx == IDX_IRQ_EN) begin
            irq_en_reg <= PWDATA_IN[NUM_LIM-1:0];
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // Read data captured in the setup cycle, so it stands in the access phase
    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= DATA_ZERO;
        end else if (PSEL_IN && !PENABLE_IN) begin
            prdata_reg <= DATA_ZERO;
            if (lim_hit) begin
                prdata_reg[LIM_W-1:0] <= lim_reg[lim_sel];
            end else if (addr_ok) begin
                unique case (idx)
                    IDX_ALARM_A:  prdata_reg[7:0] <= alarm_a;
                    IDX_ALARM_B:  prdata_reg[7:0] <= alarm_b;
                    IDX_WARN_A:   prdata_reg[7:0] <= warn_a;
                    IDX_WARN_B:   prdata_reg[7:0] <= warn_b;
                    IDX_IRQ_STAT: prdata_reg[NUM_LIM-1:0] <= irq_stat_reg;
                    IDX_IRQ_EN:   prdata_reg[NUM_LIM-1:0] <= irq_en_reg;
                    IDX_STATUS: begin
                        prdata_reg[NUM_CHAN-1:0]  <= seen_reg;
                        prdata_reg[BIT_STAT_BUSY] <= (nv_state_reg == ST_PROG);
                    end
                    default:      prdata_reg <= DATA_ZERO;
                endcase
            end
        end
    end

    assign PRDATA_OUT = prdata_reg;

endmodule // mlc_monitor_limit_compare

/* verif/mlc_conv_model.sv */
// Behavioural converter that delivers monitor measurements
`timescale 1ns/1ps
module mlc_conv_model
    import mlc_pkg::*;
(
    input  wire logic clk_in,
    output mlc_meas_t meas_out
);
    initial meas_out = '0;
    // Idle data is the inverse of the last sample, never a stale copy
    task automatic send(input logic [1:0] ch, input logic [LIM_W-1:0] d);
        @(posedge clk_in);
        meas_out <= '{valid: 1'b1, chan: ch, data: d};
        @(posedge clk_in);
        meas_out <= '{valid: 1'b0, chan: ch, data: ~d};
    endtask
endmodule // mlc_conv_model

/* verif/mlc_lim_asserts.sv */
// Port-level checker for the monitor limit compare block
`timescale 1ns/1ps
module mlc_lim_asserts
    import mlc_pkg::*;
(
    input wire logic                CORE_CLK_IN,
    input wire logic                RST_N_IN,
    input wire logic                PSEL_IN,
    input wire logic                PENABLE_IN,
    input wire logic                PWRITE_IN,
    input wire logic [ADDR_W-1:0]   PADDR_IN,
    input wire logic [DATA_W-1:0]   PWDATA_IN,
    input wire logic [DATA_W-1:0]   PRDATA_OUT,
    input wire logic                PREADY_OUT,
    input wire logic                PSLVERR_OUT,
    input wire mlc_meas_t           MEAS_IN,
    input wire logic [NUM_CHAN-1:0] CONV_SEEN_OUT,
    input wire logic                IRQ_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    logic             acc;
    logic             lim_hit;
    logic             map_hit;
    logic [IDX_W-1:0] idx;
    assign acc = PSEL_IN && PENABLE_IN;
    assign idx = PADDR_IN[9:2];
    always_comb begin
        lim_hit = 1'b0;
        for (int i = 0; i < NUM_LIM; i++)
            lim_hit = lim_hit | (idx == IDX_LIM[i]);
    end
    assign map_hit = PADDR_IN[1:0] == 2'h0 && PADDR_IN[11:10] == 2'h0 && (lim_hit || idx
        inside {IDX_ALARM_A, IDX_ALARM_B, IDX_WARN_A, IDX_WARN_B, [IDX_IRQ_STAT:IDX_CTRL]});
    chk_unmapped_err: assert property (acc && PREADY_OUT && !map_hit |-> PSLVERR_OUT)
        else $error("unmapped access not refused");
    chk_read_ready: assert property (acc && !PWRITE_IN |-> PREADY_OUT)
        else $error("read stalled");
    chk_write_wait: assert property (acc && !PREADY_OUT |-> ##[1:5] PREADY_OUT)
        else $error("store stall too long");
    chk_limit_width: assert property (acc && lim_hit |-> PRDATA_OUT[31:16] == 16'h0000)
        else $error("limit wider than 16 bits");
    chk_blank_flags: assert property (acc && idx == IDX_ALARM_A && CONV_SEEN_OUT == 3'h0
        && $past(CONV_SEEN_OUT) == 3'h0 |-> PRDATA_OUT == DATA_ZERO) else $error("early flag");
    chk_seen_set: assert property ($past(RST_N_IN, 2) && MEAS_IN.valid && MEAS_IN.chan != 2'h3
        |=> CONV_SEEN_OUT[$past(MEAS_IN.chan)]) else $error("conversion not noted");
    chk_seen_hold: assert property ((CONV_SEEN_OUT & $past(CONV_SEEN_OUT)) == $past(CONV_SEEN_OUT))
        else $error("conversion mark lost");
    chk_seen_ign: assert property (MEAS_IN.valid && MEAS_IN.chan == 2'h3 |=> $stable(CONV_SEEN_OUT))
        else $error("unused channel taken");
endmodule // mlc_lim_asserts

bind mlc_monitor_limit_compare mlc_lim_asserts i_mlc_lim_asserts (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .MEAS_IN(MEAS_IN), .CONV_SEEN_OUT(CONV_SEEN_OUT),
    .IRQ_OUT(IRQ_OUT));

/* verif/monitor_limit_compare_test.sv */
// Self-checking bench for the monitor limit compare block
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module monitor_limit_compare_test
    import mlc_pkg::*;
;
    localparam logic [IDX_W-1:0] FBYTE [NUM_LIM] = '{8'h70, 8'h74, 8'h74, 8'h70, 8'h70,
        8'h74, 8'h74, 8'h71, 8'h71, 8'h75};
    localparam int FBIT [NUM_LIM] = '{2, 3, 2, 1, 0, 1, 0, 7, 6, 7};
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata, prdata, rnd;
    mlc_meas_t           meas;
    logic [NUM_CHAN-1:0] seen, seen_exp;
    int                  num_errors, checked, cyc, k, sel;
    logic [DATA_W:0]     notes [$];
    logic [DATA_W:0]     note;
    logic [LIM_W-1:0]    lim [NUM_LIM];
    logic                flg [NUM_LIM];
    logic [NUM_LIM-1:0]  stat, en;
    mlc_monitor_limit_compare i_mlc_monitor_limit_compare (.CORE_CLK_IN(clk),
        .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .MEAS_IN(meas), .CONV_SEEN_OUT(seen), .IRQ_OUT(irq));
    mlc_conv_model i_mlc_conv_model (.clk_in(clk), .meas_out(meas));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic test_done();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [IDX_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, a, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [IDX_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [IDX_W-1:0] a, input logic [DATA_W:0] e);
        notes.push_back(e);
        apb(1'b0, a, DATA_ZERO);
    endtask
    function automatic logic [DATA_W:0] fbyte(input logic [IDX_W-1:0] b);
        logic [DATA_W:0] v;
        v = '0;
        for (int i = 0; i < NUM_LIM; i++)
            if (FBYTE[i] == b && flg[i]) v[FBIT[i]] = 1'b1;
        return v;
    endfunction
    task automatic meas_go(input logic [1:0] ch, input logic [LIM_W-1:0] d);
        logic nf;
        i_mlc_conv_model.send(ch, d);
        if (ch != 2'h3) seen_exp[ch] = 1'b1;
        for (int i = 0; i < NUM_LIM; i++) begin
            if (LIM_CHAN[i] == ch) begin
                // Equal leaves the flag as it was
                nf = (d > lim[i]) ? LIM_HIGH[i] : (d < lim[i]) ? !LIM_HIGH[i] : flg[i];
                stat[i] = stat[i] | (nf & !flg[i]);
                flg[i] = nf;
            end
        end
    endtask
    task automatic chk_flags();
        rd(IDX_ALARM_A, fbyte(8'h70));
        rd(IDX_ALARM_B, fbyte(8'h71));
        rd(IDX_WARN_A, fbyte(8'h74));
        rd(IDX_WARN_B, fbyte(8'h75));
        rd(IDX_IRQ_STAT, {23'h0, stat});
        rd(IDX_STATUS, {30'h0, seen_exp});
        `CHK(irq, |(stat & en))
        `CHK(seen, seen_exp)
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (lim[i]) lim[i] = '0;
        foreach (flg[i]) flg[i] = 1'b0;
        {stat, en, seen_exp} = '0;
    endtask
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
            note = notes.pop_front();
            `CHK({pslverr, prdata}, note)
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {num_errors, checked, cyc} = '0;
        void'($urandom(50914));
        do_reset();
        foreach (IDX_LIM[i]) rd(IDX_LIM[i], '0);
        chk_flags();
        rd(8'h30, {1'b1, DATA_ZERO});
        rd(IDX_IRQ_CLR, '0);
        foreach (lim[i]) begin
            rnd = $urandom;
            lim[i] = rnd[15:0];
            wr(IDX_LIM[i], rnd);
        end
        wr(IDX_CTRL, 32'h0000_0001);
        foreach (IDX_LIM[i]) rd(IDX_LIM[i], {17'h0, lim[i]});
        wr(IDX_ALARM_A, 32'hFFFF_FFFF);
        en = 10'h3FF;
        wr(IDX_IRQ_EN, {22'h0, en});
        meas_go(2'h3, 16'h1234);
        chk_flags();
        repeat (60) begin
            k = $urandom % NUM_LIM;
            sel = $urandom % 4;
            rnd = $urandom;
            meas_go(LIM_CHAN[k], sel == 0 ? rnd[15:0] : lim[k] + 16'(sel) - 16'h0002);
            if (rnd[16]) begin
                wr(IDX_IRQ_CLR, {22'h0, rnd[26:17]});
                stat = stat & ~rnd[26:17];
            end
            if (sel == 1) begin
                en = rnd[31:22];
                wr(IDX_IRQ_EN, {22'h0, en});
            end
            chk_flags();
        end
        do_reset();
        rd(IDX_LIM[0], '0);
        chk_flags();
        meas_go(2'h1, 16'h0000);
        chk_flags();
        test_done();
    end
endmodule // monitor_limit_compare_test
